// File: dv/scs_clock_select_monitor.sv
`timescale 1ns/1ps
module scs_clock_select_monitor
   import scs_pkg::*;
#(
   parameter int STABLE_TICKS      = 16,
   parameter int TIMER_READY_EDGES = 64
) (
   // Clock and reset.
   input wire logic       i_mclk,
   input wire logic       i_rst,
   // Watched inputs.
   input wire logic [2:0] i_config_osc_select,
   input wire logic       i_clock_output_enable,
   input wire logic       i_css_write,
   input wire logic [1:0] i_css_wdata,
   input wire logic       i_timer_osc_enable,
   // Watched outputs.
   input wire logic [1:0] o_clock_source_select,
   input wire logic       o_startup_timer_status,
   input wire logic       o_timer_osc_ready,
   input wire logic       o_cpu_clk_tick,
   input wire logic       o_periph_clk_tick,
   input wire logic       o_clkin_is_gpio,
   input wire logic       o_clkout_is_gpio,
   input wire logic       o_clkout_out,
   input wire logic       o_clkout_oe_n
);
   // All checks live in the one master clock domain.
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // High while the configuration word picks the internal block.
   wire logic int_mode = (i_config_osc_select == CFG_INTERNAL_OSC_BLOCK);
   // A software write and its readback one cycle later.
   sequence s_write; i_css_write; endsequence
   sequence s_readback; o_clock_source_select == $past(i_css_wdata); endsequence
   // A single system tick.
   sequence s_tick; o_cpu_clk_tick; endsequence
   // Reset itself is watched, so it cannot also disable this one.
   property p_reset;
      disable iff (1'b0) i_rst |=> (o_clock_source_select == CSS_RESET)
         && !o_startup_timer_status && !o_timer_osc_ready && !o_cpu_clk_tick;
   endproperty
   property p_write; s_write |=> s_readback; endproperty
   property p_hold; !i_css_write |=> $stable(o_clock_source_select); endproperty
   property p_same_tick; o_cpu_clk_tick == o_periph_clk_tick; endproperty
   property p_no_runt; s_tick |=> !o_cpu_clk_tick; endproperty
   property p_clkin; o_clkin_is_gpio == int_mode; endproperty
   property p_clkout;
      (o_clkout_oe_n == !(int_mode && i_clock_output_enable))
         && (o_clkout_is_gpio == (int_mode && !i_clock_output_enable));
   endproperty
   property p_toggle; $changed(o_clkout_out) |-> o_cpu_clk_tick || $past(o_cpu_clk_tick);
   endproperty
   property p_ready_off; !i_timer_osc_enable |=> !o_timer_osc_ready; endproperty
   property p_status; o_startup_timer_status |-> !int_mode; endproperty
   a_reset: assert property (p_reset) else $error("field or flags not cleared by reset");
   a_write: assert property (p_write) else $error("select field readback wrong");
   a_hold: assert property (p_hold) else $error("select field changed without a write");
   a_same_tick: assert property (p_same_tick) else $error("cpu and peripheral ticks differ");
   a_no_runt: assert property (p_no_runt) else $error("back to back system ticks");
   a_clkin: assert property (p_clkin) else $error("clock input pin function wrong");
   a_clkout: assert property (p_clkout) else $error("clock output pin function wrong");
   a_toggle: assert property (p_toggle) else $error("clock output moved without a tick");
   a_ready_off: assert property (p_ready_off) else $error("ready kept with oscillator off");
   a_status: assert property (p_status) else $error("status set in internal mode");
endmodule
bind scs_system_clock_select scs_clock_select_monitor #(
   .STABLE_TICKS(STABLE_TICKS), .TIMER_READY_EDGES(TIMER_READY_EDGES)
) u_mon (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_config_osc_select(i_config_osc_select),
   .i_clock_output_enable(i_clock_output_enable), .i_css_write(i_css_write),
   .i_css_wdata(i_css_wdata), .i_timer_osc_enable(i_timer_osc_enable),
   .o_clock_source_select(o_clock_source_select), .o_timer_osc_ready(o_timer_osc_ready),
   .o_startup_timer_status(o_startup_timer_status), .o_cpu_clk_tick(o_cpu_clk_tick),
   .o_periph_clk_tick(o_periph_clk_tick), .o_clkin_is_gpio(o_clkin_is_gpio),
   .o_clkout_is_gpio(o_clkout_is_gpio), .o_clkout_out(o_clkout_out),
   .o_clkout_oe_n(o_clkout_oe_n)
);

// File: dv/scs_system_clock_select_tb.sv
`timescale 1ns/1ps
module scs_system_clock_select_tb
   import scs_pkg::*;
   ;
   // Short qualification counts keep the run brief; the cycle ceiling cuts a hang.
   // The tests need about 82,000 cycles; the ceiling leaves some margin above that.
   localparam int MAX_CYC = 90000;
   // Design inputs, all given a value at time zero.
   logic       i_mclk = 1'b0;
   logic       i_rst = 1'b1;
   logic [2:0] i_config_osc_select = CFG_LP;
   logic       i_clock_output_enable = 1'b0;
   logic       i_css_write = 1'b0;
   logic [1:0] i_css_wdata = 2'h0;
   logic [3:0] i_internal_freq_select = 4'h0;
   logic [5:0] i_osc_tuning = 6'h0;
   logic       i_timer_osc_enable = 1'b0;
   logic       i_clock_input_pin = 1'b0;
   logic       i_timer_crystal_in_pin = 1'b0;
   // Design outputs.
   logic [1:0] o_clock_source_select;
   logic       o_startup_timer_status, o_timer_osc_ready, o_cpu_clk_tick, o_periph_clk_tick;
   logic       o_clkin_is_gpio, o_clkout_is_gpio, o_clkout_out, o_clkout_oe_n;
   // Score keeping.
   int n_errors = 0;
   int compares = 0;
   int tick_cnt = 0;
   int cyc = 0;

`define CHK(name, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", name, exp, got); end end

   scs_system_clock_select #(.STABLE_TICKS(2), .TIMER_READY_EDGES(2)) DUT (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_config_osc_select(i_config_osc_select),
      .i_clock_output_enable(i_clock_output_enable), .i_css_write(i_css_write),
      .i_css_wdata(i_css_wdata), .i_internal_freq_select(i_internal_freq_select),
      .i_osc_tuning(i_osc_tuning), .i_timer_osc_enable(i_timer_osc_enable),
      .i_clock_input_pin(i_clock_input_pin), .i_timer_crystal_in_pin(i_timer_crystal_in_pin),
      .o_clock_source_select(o_clock_source_select), .o_timer_osc_ready(o_timer_osc_ready),
      .o_startup_timer_status(o_startup_timer_status), .o_cpu_clk_tick(o_cpu_clk_tick),
      .o_periph_clk_tick(o_periph_clk_tick), .o_clkin_is_gpio(o_clkin_is_gpio),
      .o_clkout_is_gpio(o_clkout_is_gpio), .o_clkout_out(o_clkout_out),
      .o_clkout_oe_n(o_clkout_oe_n));

   // The 8 ns master clock.
   always #4 i_mclk = ~i_mclk;

   // Counts system ticks and cycles; the ceiling counts as a failure.
   always @(posedge i_mclk) begin
      cyc++;
      if (o_cpu_clk_tick === 1'b1) tick_cnt++;
      if (cyc == MAX_CYC) begin
         n_errors++;
         give_verdict();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Waits n edges and lands just after the last, where inputs change.
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   // One-cycle write pulse into the source select field.
   task automatic wr_css(input logic [1:0] v);
      i_css_write = 1'b1;
      i_css_wdata = v;
      step(1);
      i_css_write = 1'b0;
   endtask

   // Gives n rising edges on a crystal pin, four master cycles each.
   task automatic pins(input bit tmr, input int n);
      repeat (n) begin
         if (tmr) i_timer_crystal_in_pin = 1'b1; else i_clock_input_pin = 1'b1;
         step(2);
         if (tmr) i_timer_crystal_in_pin = 1'b0; else i_clock_input_pin = 1'b0;
         step(2);
      end
   endtask

   // Counts system ticks over n master cycles.
   task automatic measure(input int n, output int cnt);
      int t0;
      t0 = tick_cnt;
      step(n);
      cnt = tick_cnt - t0;
   endtask

   initial begin
      int n;
      int m;
      step(3);
      i_rst = 1'b0;
      `CHK("field", CSS_RESET, o_clock_source_select)
      `CHK("status", 1'b0, o_startup_timer_status)
      `CHK("ready", 1'b0, o_timer_osc_ready)
      $display("test reset done");
      // The timer crystal runs; the start-up timer must not count it.
      i_timer_osc_enable = 1'b1;
      pins(1, 1100);
      `CHK("ready", 1'b1, o_timer_osc_ready)
      `CHK("status", 1'b0, o_startup_timer_status)
      // Ready seen first, so selecting the crystal is allowed.
      wr_css(2'h1);
      `CHK("field", 2'h1, o_clock_source_select)
      pins(1, 10);
      m = tick_cnt;
      pins(1, 40);
      `CHK("timer ticks", 1'b1, (tick_cnt - m >= 39 && tick_cnt - m <= 41))
      `CHK("status", 1'b0, o_startup_timer_status)
      // Switching the crystal off must drop ready on the next edge.
      i_timer_osc_enable = 1'b0;
      step(1);
      `CHK("ready off", 1'b0, o_timer_osc_ready)
      $display("test timer crystal done");
      // Crystal now idle: no tick may come until the new source qualifies.
      i_internal_freq_select = 4'hF;
      wr_css(2'h2);
      measure(8, n);
      `CHK("early ticks", 0, n)
      measure(200, n);
      `CHK("internal ticks", 1'b1, n > 0)
      $display("test switch delay done");
      // 16 MHz gives 800 ticks in 6250 cycles; a raised trim must speed it up.
      measure(6250, n);
      `CHK("high count", 1'b1, (n >= 797 && n <= 803))
      i_osc_tuning = 6'h1F;
      step(50);
      measure(6250, m);
      `CHK("tuned count", 1'b1, m >= n + 4)
      i_osc_tuning = 6'h0;
      // Half the high source: 8 MHz gives 400 ticks in 6250 cycles.
      i_internal_freq_select = 4'hE;
      step(100);
      measure(6250, n);
      `CHK("half high count", 1'b1, (n >= 398 && n <= 402))
      i_internal_freq_select = 4'h7;
      step(1100);
      measure(12500, n);
      `CHK("mid count", 1'b1, (n >= 49 && n <= 51))
      i_internal_freq_select = 4'h0;
      step(16200);
      measure(24000, n);
      `CHK("low count", 1'b1, (n >= 5 && n <= 7))
      $display("test frequencies done");
      // Back to the configured crystal: internal until the start-up timer expires.
      wr_css(2'h0);
      pins(0, 1000);
      `CHK("status", 1'b0, o_startup_timer_status)
      pins(0, 40);
      `CHK("status", 1'b1, o_startup_timer_status)
      `CHK("field", 2'h0, o_clock_source_select)
      m = tick_cnt;
      pins(0, 20);
      `CHK("ext ticks", 1'b1, (tick_cnt - m >= 19 && tick_cnt - m <= 21))
      $display("test start-up done");
      // Back to back writes of every select code.
      i_css_write = 1'b1;
      for (int v = 0; v < 4; v++) begin
         i_css_wdata = v[1:0];
         step(1);
         `CHK("field", v[1:0], o_clock_source_select)
      end
      i_css_write = 1'b0;
      step(1);
      // A second reset, now with the internal configuration.
      i_rst = 1'b1;
      i_config_osc_select = CFG_INTERNAL_OSC_BLOCK;
      step(3);
      i_rst = 1'b0;
      `CHK("field", CSS_RESET, o_clock_source_select)
      for (int e = 0; e < 2; e++) begin
         i_clock_output_enable = e[0];
         step(1);
         `CHK("clkin gpio", 1'b1, o_clkin_is_gpio)
         `CHK("clkout oe", ~e[0], o_clkout_oe_n)
      end
      $display("test pins done");
      give_verdict();
   end
endmodule

// File: include/scs_pkg.sv
package scs_pkg;

   // Master clock rate that every internal oscillator model is derived from.
   localparam longint CLK_HZ       = 64'd125_000_000;
   // Nominal internal oscillator frequencies.
   localparam longint MF_HZ        = 64'd500_000;
   localparam longint LF_HZ        = 64'd31_000;
   // The high-frequency source is the mid-frequency source times two to the power of this value.
   localparam int     PLL_MULT_LOG = 5;
   // Width of the phase accumulators that model the oscillators.
   localparam int     NCO_W        = 24;

   // Phase increments per master cycle, derived from the nominal rates.
   localparam logic [NCO_W-1:0] MF_INC = NCO_W'((MF_HZ << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] LF_INC = NCO_W'((LF_HZ << NCO_W) / CLK_HZ);
   // Position of the tuning value inside the increment.
   localparam int     TUNE_POS     = 4;

   // Edges the start-up timer counts on the crystal before it expires.
   localparam int     ST_EDGES     = 1024;
   localparam int     ST_CNT_W     = 11;

   // Configuration oscillator select encodings.
   localparam logic [2:0] CFG_LP     = 3'h0;
   localparam logic [2:0] CFG_XT     = 3'h1;
   localparam logic [2:0] CFG_HS     = 3'h2;
   localparam logic [2:0] CFG_INTERNAL_OSC_BLOCK = 3'h4;

   // Source key kinds: top two bits of a six bit source key.
   localparam logic [1:0] KIND_EXT   = 2'h0;
   localparam logic [1:0] KIND_TMR   = 2'h1;
   localparam logic [1:0] KIND_INT   = 2'h2;

   // Reset values.
   localparam logic [1:0] CSS_RESET  = 2'h0;
   localparam logic [5:0] KEY_RESET  = 6'h20;

   // Clock switch sequencer states.
   typedef enum logic [0:0] {
      SCS_RUN,
      SCS_WAIT
   } scs_state_type;

endpackage

// File: rtl/scs_system_clock_select.sv
`timescale 1ns/1ps
// Operation
// - Internal block via config or run-time select.
// - Internal mode frees input pin, optional clock out.
// - High source is mid source times PLL, tunable.
// - Tunable calibrated mid oscillator at 500 kHz.
// - Untrimmed low oscillator at 31 kHz.
// - Selected clock drives processor and peripherals.
// - Select 00 uses configured default source.
// - Select 01 uses timer crystal oscillator.
// - Select 1x uses internal frequency select.
// - Every reset clears the source select.
// - Automatic switches leave select field unchanged.
// - Wait for new clock stable before use.
// - Status flag shows external source after timeout.
// - Start-up timer ignores the timer oscillator.
// - Timer crystal enabled by its enable bit.
module scs_system_clock_select
   import scs_pkg::*;
#(
   parameter int STABLE_TICKS      = 16,
   parameter int TIMER_READY_EDGES = 64
) (
   // Clock and reset.
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // Configuration word fields.
   input  wire logic [2:0] i_config_osc_select,
   input  wire logic       i_clock_output_enable,
   // Software control fields.
   input  wire logic       i_css_write,
   input  wire logic [1:0] i_css_wdata,
   input  wire logic [3:0] i_internal_freq_select,
   input  wire logic [5:0] i_osc_tuning,
   input  wire logic       i_timer_osc_enable,
   // Pins from outside the clock domain.
   input  wire logic       i_clock_input_pin,
   input  wire logic       i_timer_crystal_in_pin,
   // Software status fields.
   output logic [1:0]      o_clock_source_select,
   output logic            o_startup_timer_status,
   output logic            o_timer_osc_ready,
   // System clock enables.
   output logic            o_cpu_clk_tick,
   output logic            o_periph_clk_tick,
   // Pin functions.
   output logic            o_clkin_is_gpio,
   output logic            o_clkout_is_gpio,
   output logic            o_clkout_out,
   output logic            o_clkout_oe_n
);

   // Refuse counts that the sequencer and ready counter cannot serve.
   if (STABLE_TICKS < 1 || STABLE_TICKS > 255) begin : g_bad_stable
      $error("STABLE_TICKS out of range");
   end
   if (TIMER_READY_EDGES < 1 || TIMER_READY_EDGES > 65535) begin : g_bad_ready
      $error("TIMER_READY_EDGES out of range");
   end

   // Tick of a power-of-two postscaler: every 2**shift source ticks.
   function automatic logic div_tick(input logic src, input logic [6:0] cnt,
                                     input int shift);
      logic [6:0] mask;
      mask = 7'((1 << shift) - 1);
      return src && ((cnt & mask) == 7'h00);
   endfunction

   // Internal frequency select mapped onto the three internal sources.
   function automatic logic int_tick(input logic [3:0] ifs, input logic hf,
                                     input logic mf, input logic lf,
                                     input logic [6:0] hc, input logic [6:0] mc);
      if (ifs >= 4'h8) begin
         return div_tick(hf, hc, 15 - int'(ifs));
      end else if (ifs >= 4'h2) begin
         return div_tick(mf, mc, 7 - int'(ifs));
      end else begin
         return lf;
      end
   endfunction

   // Synchronisers: two flops each, a third stage only for edge detection.
   logic [2:0] clkin_sync;          // Clock input pin pipeline.
   logic [2:0] tmr_sync;            // Timer crystal pin pipeline.
   logic [2:0] next_clkin_sync;
   logic [2:0] next_tmr_sync;
   logic       ext_tick;            // Rising edge of the configured clock.
   logic       tmr_edge;            // Rising edge of the timer crystal.

   // Sample both pins; nothing reads stage zero except stage one.
   always_comb begin
      next_clkin_sync = {clkin_sync[1:0], i_clock_input_pin};
      next_tmr_sync   = {tmr_sync[1:0], i_timer_crystal_in_pin};
   end

   // Register the synchroniser stages.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         clkin_sync <= 3'h0;
         tmr_sync   <= 3'h0;
      end else begin
         clkin_sync <= next_clkin_sync;
         tmr_sync   <= next_tmr_sync;
      end
   end

   assign ext_tick = clkin_sync[1] && !clkin_sync[2];
   // The crystal amplifier only runs while its enable bit is set.
   // enable gates crystal.
   assign tmr_edge = tmr_sync[1] && !tmr_sync[2] && i_timer_osc_enable;

   // Internal oscillator models as phase accumulators.
   logic [NCO_W-1:0] mf_acc;        // Mid-frequency phase.
   logic [NCO_W-1:0] hf_acc;        // High-frequency phase.
   logic [NCO_W-1:0] lf_acc;        // Low-frequency phase.
   logic             mf_tick;       // Mid-frequency period tick.
   logic             hf_tick;       // High-frequency period tick.
   logic             lf_tick;       // Low-frequency period tick.
   logic [6:0]       mf_div;        // Mid-frequency postscaler.
   logic [6:0]       hf_div;        // High-frequency postscaler.
   logic [NCO_W-1:0] next_mf_acc;
   logic [NCO_W-1:0] next_hf_acc;
   logic [NCO_W-1:0] next_lf_acc;
   logic             next_mf_tick;
   logic             next_hf_tick;
   logic             next_lf_tick;
   logic [6:0]       next_mf_div;
   logic [6:0]       next_hf_div;
   logic [NCO_W-1:0] mf_inc;        // Tuned mid-frequency increment.
   logic [NCO_W-1:0] hf_inc;        // Multiplied increment for the high source.

   // Advance each oscillator; the carry out of an accumulator is one period.
   always_comb begin
      mf_inc = MF_INC + NCO_W'({{(NCO_W-6-TUNE_POS){i_osc_tuning[5]}}, i_osc_tuning,
                                {TUNE_POS{1'b0}}});
      hf_inc = NCO_W'({mf_inc, {PLL_MULT_LOG{1'b0}}});
      {next_mf_tick, next_mf_acc} = {1'b0, mf_acc} + {1'b0, mf_inc};
      {next_hf_tick, next_hf_acc} = {1'b0, hf_acc} + {1'b0, hf_inc};
      {next_lf_tick, next_lf_acc} = {1'b0, lf_acc} + {1'b0, LF_INC};
      next_mf_div = mf_tick ? mf_div + 7'h01 : mf_div;
      next_hf_div = hf_tick ? hf_div + 7'h01 : hf_div;
   end

   // Register the oscillator models.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mf_acc  <= '0;
         hf_acc  <= '0;
         lf_acc  <= '0;
         mf_tick <= 1'b0;
         hf_tick <= 1'b0;
         lf_tick <= 1'b0;
         mf_div  <= 7'h00;
         hf_div  <= 7'h00;
      end else begin
         mf_acc  <= next_mf_acc;
         hf_acc  <= next_hf_acc;
         lf_acc  <= next_lf_acc;
         mf_tick <= next_mf_tick;
         hf_tick <= next_hf_tick;
         lf_tick <= next_lf_tick;
         mf_div  <= next_mf_div;
         hf_div  <= next_hf_div;
      end
   end

   // Software select field, start-up timer and timer oscillator ready.
   logic [1:0]          css;            // Clock source select field.
   logic [ST_CNT_W-1:0] st_cnt;         // Start-up timer edge count.
   logic                st_done;        // Start-up timer expired.
   logic [15:0]         rdy_cnt;        // Timer crystal edge count.
   logic                tmr_ready;      // Timer oscillator ready flag.
   logic [1:0]          next_css;
   logic [ST_CNT_W-1:0] next_st_cnt;
   logic                next_st_done;
   logic [15:0]         next_rdy_cnt;
   logic                next_tmr_ready;
   logic                xtal_mode;      // Configured for a crystal mode.

   assign xtal_mode = (i_config_osc_select == CFG_LP) ||
                      (i_config_osc_select == CFG_XT) ||
                      (i_config_osc_select == CFG_HS);

   // Compute the control field and the two timers.
   always_comb begin
      // Only software writes change the field; automatic switching never does.
      // field left alone.
      next_css = i_css_write ? i_css_wdata : css;
      // The start-up timer counts only the configured clock pin.
      // timer crystal ignored.
      next_st_cnt  = st_cnt;
      next_st_done = st_done;
      if (!st_done && ext_tick) begin
         next_st_cnt = st_cnt + ST_CNT_W'(1);
         next_st_done = (st_cnt == ST_CNT_W'(ST_EDGES - 1));
      end
      // Ready drops at once when the crystal is switched off.
      next_rdy_cnt   = rdy_cnt;
      next_tmr_ready = tmr_ready;
      if (!i_timer_osc_enable) begin
         next_rdy_cnt   = 16'h0000;
         next_tmr_ready = 1'b0;
      end else if (!tmr_ready && tmr_edge) begin
         next_rdy_cnt   = rdy_cnt + 16'h0001;
         next_tmr_ready = (rdy_cnt == 16'(TIMER_READY_EDGES - 1));
      end
   end

   // Register the control field and timers.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         css       <= CSS_RESET;
         st_cnt    <= '0;
         st_done   <= 1'b0;
         rdy_cnt   <= 16'h0000;
         tmr_ready <= 1'b0;
      end else begin
         css       <= next_css;
         st_cnt    <= next_st_cnt;
         st_done   <= next_st_done;
         rdy_cnt   <= next_rdy_cnt;
         tmr_ready <= next_tmr_ready;
      end
   end

   // Target source key and the tick of any key.
   logic [5:0] target_key;

   // Tick of a source named by its key.
   function automatic logic key_tick(input logic [5:0] key, input logic e,
                                     input logic t, input logic hf,
                                     input logic mf, input logic lf,
                                     input logic [6:0] hc, input logic [6:0] mc);
      if (key[5:4] == KIND_EXT) begin
         return e;
      end else if (key[5:4] == KIND_TMR) begin
         return t;
      end else begin
         return int_tick(key[3:0], hf, mf, lf, hc, mc);
      end
   endfunction

   // Decide which source the system clock should come from.
   always_comb begin
      if (css[1]) begin
         target_key = {KIND_INT, i_internal_freq_select};
      end else if (css[0]) begin
         target_key = {KIND_TMR, 4'h0};
      end else if (i_config_osc_select == CFG_INTERNAL_OSC_BLOCK) begin
         target_key = {KIND_INT, i_internal_freq_select};
      end else if (xtal_mode && !st_done) begin
         // Two-speed start: run internally until the crystal has settled.
         target_key = {KIND_INT, i_internal_freq_select};
      end else begin
         target_key = {KIND_EXT, 4'h0};
      end
   end

   // Clock switch sequencer.
   scs_state_type state;            // Sequencer state.
   logic [5:0]    cur_key;          // Source now driving the system clock.
   logic [5:0]    new_key;          // Source being qualified.
   logic [7:0]    stab_cnt;         // Ticks of the new source seen so far.
   logic          sys_tick;         // Registered system clock enable.
   logic          clkout;           // Clock output pin level.
   scs_state_type next_state;
   logic [5:0]    next_cur_key;
   logic [5:0]    next_new_key;
   logic [7:0]    next_stab_cnt;
   logic          next_sys_tick;
   logic          next_clkout;
   logic          cur_t;            // Tick of the current source.
   logic          new_t;            // Tick of the qualifying source.

   // Keep the old clock until the new one has shown enough periods.
   always_comb begin
      cur_t = key_tick(cur_key, ext_tick, tmr_edge, hf_tick, mf_tick, lf_tick,
                       hf_div, mf_div);
      new_t = key_tick(new_key, ext_tick, tmr_edge, hf_tick, mf_tick, lf_tick,
                       hf_div, mf_div);
      next_state    = state;
      next_cur_key  = cur_key;
      next_new_key  = new_key;
      next_stab_cnt = stab_cnt;
      next_sys_tick = cur_t;
      case (state)
         SCS_RUN: begin
            if (target_key != cur_key) begin
               next_state    = SCS_WAIT;
               next_new_key  = target_key;
               next_stab_cnt = 8'h00;
            end
         end
         SCS_WAIT: begin
            if (target_key != new_key) begin
               // A fresh request restarts qualification from zero.
               next_new_key  = target_key;
               next_stab_cnt = 8'h00;
               if (target_key == cur_key) begin
                  next_state = SCS_RUN;
               end
            end else if (new_t && stab_cnt < 8'(STABLE_TICKS)) begin
               next_stab_cnt = stab_cnt + 8'h01;
            end else if (new_t && !sys_tick) begin
               // Change over on a new edge with no old edge just before it.
               // glitch free changeover.
               next_cur_key  = new_key;
               next_state    = SCS_RUN;
               next_sys_tick = 1'b1;
            end
         end
         default: begin
            next_state = SCS_RUN;
         end
      endcase
      // The clock output pin toggles on every system clock period.
      next_clkout = sys_tick ? !clkout : clkout;
   end

   // Register the sequencer.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state    <= SCS_RUN;
         cur_key  <= KEY_RESET;
         new_key  <= KEY_RESET;
         stab_cnt <= 8'h00;
         sys_tick <= 1'b0;
         clkout   <= 1'b0;
      end else begin
         state    <= next_state;
         cur_key  <= next_cur_key;
         new_key  <= next_new_key;
         stab_cnt <= next_stab_cnt;
         sys_tick <= next_sys_tick;
         clkout   <= next_clkout;
      end
   end

   // Status and clock outputs.
   assign o_clock_source_select  = css;
   assign o_startup_timer_status = (cur_key[5:4] == KIND_EXT);
   assign o_timer_osc_ready      = tmr_ready;
   assign o_cpu_clk_tick         = sys_tick;
   assign o_periph_clk_tick      = sys_tick;

   // In internal mode the input pin is free and the output pin is optional.
   // pin functions.
   assign o_clkin_is_gpio  = (i_config_osc_select == CFG_INTERNAL_OSC_BLOCK);
   assign o_clkout_is_gpio = (i_config_osc_select == CFG_INTERNAL_OSC_BLOCK) && !i_clock_output_enable;
   assign o_clkout_oe_n    = !((i_config_osc_select == CFG_INTERNAL_OSC_BLOCK) && i_clock_output_enable);
   assign o_clkout_out     = clkout;

endmodule
